// *** hw/pd_transmit_and_vbus_regs.sv ***
// transmit request, payload port and bus voltage register logic
// assumes a serial slave front end presenting byte accesses on reg_*
// What this block does
// - request write starts sending the loaded message
// - send all bytes since pointer reset
// - after each attempt empty buffer; clear count unless a transaction or count byte lands that cycle
// - bits 5:4 give zero to three retries
// - bits 2:0 choose the frame kind
// - payload bytes only via write-only port
// - ten bit measurement split low/high registers
// - measurement valid only while monitor enabled
// - scale field always reads zero
// - ten bit threshold, low byte resets 0x20
// - low codes mean 0.5 V floor
// - lowest two threshold bits are ignored
// - high threshold register holds bits 9:8
`timescale 1ns/1ns
module pd_transmit_and_vbus_regs
    import pd_regs_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        xact_start,     // new write transaction begins
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    output logic      [7:0]  reg_rdata,
    output logic             payload_ready,  // buffer can take a byte
    input  wire logic        clear_outgoing_pointer_cmd,
    input  wire logic        volt_monitor_on,
    input  wire logic        adc_valid,
    input  wire logic [9:0]  adc_code,
    output logic             tx_start,
    output logic      [2:0]  outgoing_frame_kind,
    output logic      [1:0]  tx_retries,
    output logic      [7:0]  tx_length,
    output logic             tx_busy,
    input  wire logic        tx_done,        // end of attempt, any outcome
    output logic             tx_data_valid,
    input  wire logic        tx_data_ready,
    output logic      [7:0]  tx_data,
    output logic      [9:0]  discharge_stop_level,
    output logic      [9:0]  stop_level_eff  // effective code, 25 mV units
);
    // ==========================================================
    // state
    logic [7:0] tx_request_q;         // last request written
    logic       tx_start_q;           // one cycle start pulse
    logic [7:0] tx_length_q;          // length handed to the line side
    logic       busy_q;               // attempt in progress
    logic [7:0] wr_count_q;           // byte count of current burst
    logic [7:0] remain_q;             // payload bytes still expected
    logic       first_q;              // next payload write is the count
    logic [7:0] accum_q;              // bytes since pointer reset
    logic [9:0] meas_q;               // held measurement
    logic [9:0] stop_q;               // stop discharge threshold
    logic [9:0] eff_q;                // decoded threshold
    logic [7:0] rdata_q;              // registered read data
    logic [7:0] fifo_data;
    logic       fifo_valid;
    logic       fifo_in_ready;
    logic       req_wr;
    logic       pay_wr;
    logic       append;
    logic       flush;

    assign req_wr = reg_wr && (reg_addr == TX_REQUEST_OFS);
    assign pay_wr = reg_wr && (reg_addr == TX_PAYLOAD_OFS);
    // bytes past the announced count are dropped
    assign append = pay_wr && !first_q && (remain_q != 8'h00)
                    && fifo_in_ready;
    // an attempt ending or an explicit command empties the buffer
    assign flush  = tx_done || clear_outgoing_pointer_cmd;

    // ==========================================================
    // transmit buffer; the line side drains it during an attempt
    byte_fifo #(
        .WIDTH (BUF_WIDTH),
        .DEPTH (BUF_DEPTH)
    ) u_buf (
        .clock     (clock),
        .rst       (rst),
        .flush     (flush),
        .in_valid  (append),
        .in_ready  (fifo_in_ready),
        .in_data   (reg_wdata),
        .out_valid (fifo_valid),
        .out_ready (tx_data_ready),
        .out_data  (fifo_data)
    );
    assign tx_data_valid = fifo_valid;
    assign tx_data       = fifo_data;
    assign payload_ready = fifo_in_ready;

    // ==========================================================
    // transmit request register and start pulse
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            tx_request_q <= TX_REQUEST_RST;
            tx_start_q   <= 1'b0;
            tx_length_q  <= 8'h00;
        end else begin
            tx_start_q <= req_wr;
            if (req_wr) begin
                // retry and kind fields kept, the rest reads zero
                tx_request_q <= {2'b00, reg_wdata[RETRY_MSB:RETRY_LSB],
                                 1'b0, reg_wdata[KIND_MSB:KIND_LSB]};
                tx_length_q  <= accum_q;
            end
        end
    end
    assign tx_start            = tx_start_q;
    assign tx_retries          = tx_request_q[RETRY_MSB:RETRY_LSB];
    assign outgoing_frame_kind = tx_request_q[KIND_MSB:KIND_LSB];
    assign tx_length           = tx_length_q;

    // ==========================================================
    // busy from start until the line side reports the attempt done
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            busy_q <= 1'b0;
        end else if (req_wr) begin
            busy_q <= 1'b1;
        end else if (tx_done) begin
            busy_q <= 1'b0;
        end
    end
    assign tx_busy = busy_q;

    // ==========================================================
    // burst tracking: count byte first, payload after it
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            first_q    <= 1'b1;
            wr_count_q <= 8'h00;
            remain_q   <= 8'h00;
        end else if (xact_start) begin
            first_q <= 1'b1;
        end else if (pay_wr && first_q) begin
            first_q    <= 1'b0;
            wr_count_q <= reg_wdata;
            remain_q   <= reg_wdata;
        end else if (tx_done) begin
            wr_count_q <= 8'h00;
            remain_q   <= 8'h00;
        end else if (append) begin
            remain_q <= 8'(remain_q - 8'h01);
        end
    end

    // ==========================================================
    // pointer: reset by request write, attempt end or command, else advances
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            accum_q <= 8'h00;
        end else if (req_wr || flush) begin
            accum_q <= 8'h00;
        end else if (append) begin
            accum_q <= 8'(accum_q + 8'h01);
        end
    end

    // ==========================================================
    // measurement only follows the converter while monitoring is on;
    // otherwise the last good value is held for software
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            meas_q <= MEAS_RST;
        end else if (adc_valid && (volt_monitor_on == MON_ON_ACTIVE)) begin
            meas_q <= adc_code;
        end
    end

    // ==========================================================
    // stop discharge threshold, both bytes read/write
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            stop_q <= STOP_LEVEL_RST;
        end else if (reg_wr && reg_addr == STOP_LOW_OFS) begin
            stop_q[7:0] <= reg_wdata;
        end else if (reg_wr && reg_addr == STOP_HIGH_OFS) begin
            stop_q[9:8] <= reg_wdata[1:0];
        end
    end
    assign discharge_stop_level = stop_q;

    // ==========================================================
    // decode: drop the two low bits, clamp small codes to the floor
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            eff_q <= STOP_LEVEL_RST;
        end else if (stop_q[9:2] <= STOP_FLOOR_STEP) begin
            eff_q <= STOP_FLOOR_CODE;
        end else begin
            eff_q <= {stop_q[9:2], 2'b00};
        end
    end
    assign stop_level_eff = eff_q;

    // ==========================================================
    // read mux; payload port and unmapped offsets read zero
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rdata_q <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                TX_REQUEST_OFS: rdata_q <= tx_request_q;
                TX_PAYLOAD_OFS: rdata_q <= 8'h00;
                MEAS_LOW_OFS:   rdata_q <= meas_q[7:0];
                MEAS_HIGH_OFS:  rdata_q <= {4'h0, SCALE_UNSCALED,
                                            meas_q[9:8]};
                STOP_LOW_OFS:   rdata_q <= stop_q[7:0];
                STOP_HIGH_OFS:  rdata_q <= {6'h00, stop_q[9:8]};
                default:        rdata_q <= 8'h00;
            endcase
        end
    end
    assign reg_rdata = rdata_q;

    // ==========================================================
    // checks
    sequence s_req_write;
        reg_wr && reg_addr == TX_REQUEST_OFS;
    endsequence
    // the pulse may only stay up when a second request follows directly
    sequence s_start_seen;
        tx_start ##1 (!tx_start || $past(req_wr));
    endsequence

    property p_start;
        @(posedge clock) disable iff (rst)
        s_req_write |=> s_start_seen;
    endproperty
    a_start: assert property (p_start)
        else $error("request write did not give one start pulse");

    property p_len;
        @(posedge clock) disable iff (rst)
        s_req_write |=> tx_length == $past(accum_q) && accum_q == 8'h00;
    endproperty
    a_len: assert property (p_len)
        else $error("length or pointer wrong after request");

    property p_done;
        @(posedge clock) disable iff (rst)
        tx_done && !xact_start && !(pay_wr && first_q)
            |=> wr_count_q == 8'h00 && !tx_data_valid;
    endproperty
    a_done: assert property (p_done)
        else $error("count or buffer not cleared after attempt");

    property p_fields;
        @(posedge clock) disable iff (rst)
        s_req_write |=> tx_retries == $past(reg_wdata[5:4])
            && outgoing_frame_kind == $past(reg_wdata[2:0]);
    endproperty
    a_fields: assert property (p_fields)
        else $error("retry or kind field not taken");

    property p_append;
        @(posedge clock) disable iff (rst)
        append && !tx_done && !clear_outgoing_pointer_cmd && !req_wr
            |=> accum_q == 8'($past(accum_q) + 8'h01);
    endproperty
    a_append: assert property (p_append)
        else $error("payload byte did not advance pointer");

    property p_wo;
        @(posedge clock) disable iff (rst)
        reg_rd && reg_addr == TX_PAYLOAD_OFS |=> reg_rdata == 8'h00;
    endproperty
    a_wo: assert property (p_wo)
        else $error("payload port read back data");

    property p_hold;
        @(posedge clock) disable iff (rst)
        volt_monitor_on != MON_ON_ACTIVE |=> $stable(meas_q);
    endproperty
    a_hold: assert property (p_hold)
        else $error("measurement moved while monitor off");

    property p_scale;
        @(posedge clock) disable iff (rst)
        reg_rd && reg_addr == MEAS_HIGH_OFS
            |=> reg_rdata[7:2] == 6'h00
                && reg_rdata[1:0] == $past(meas_q[9:8]);
    endproperty
    a_scale: assert property (p_scale)
        else $error("high measurement read wrong");

    property p_eff;
        @(posedge clock) disable iff (rst)
        stop_q[9:2] > STOP_FLOOR_STEP
            |=> eff_q[1:0] == 2'b00 && eff_q[9:2] == $past(stop_q[9:2]);
    endproperty
    a_eff: assert property (p_eff)
        else $error("threshold low bits not ignored");

    // small codes all land on the fixed minimum level
    property p_floor;
        @(posedge clock) disable iff (rst)
        stop_q[9:2] <= STOP_FLOOR_STEP |=> eff_q == STOP_FLOOR_CODE;
    endproperty
    a_floor: assert property (p_floor)
        else $error("small threshold code not clamped to floor");
endmodule

// *** hw/pd_regs_pkg.sv ***
// constants for the transmit request, payload port and bus voltage registers
// assumes a byte wide register port fed by a serial slave front end
package pd_regs_pkg;
    // register offsets
    localparam logic [7:0] TX_REQUEST_OFS    = 8'h50;
    localparam logic [7:0] TX_PAYLOAD_OFS    = 8'h51;
    localparam logic [7:0] MEAS_LOW_OFS      = 8'h70;
    localparam logic [7:0] MEAS_HIGH_OFS     = 8'h71;
    localparam logic [7:0] STOP_LOW_OFS      = 8'h74;
    localparam logic [7:0] STOP_HIGH_OFS     = 8'h75;
    // field positions in the transmit request register
    localparam int RETRY_LSB = 4;
    localparam int RETRY_MSB = 5;
    localparam int KIND_LSB  = 0;
    localparam int KIND_MSB  = 2;
    // values after reset
    localparam logic [7:0] TX_REQUEST_RST    = 8'h00;
    localparam logic [9:0] STOP_LEVEL_RST    = 10'h020;
    localparam logic [9:0] MEAS_RST          = 10'h000;
    localparam logic [1:0] SCALE_UNSCALED    = 2'h0;
    // threshold decode: codes up to this floor all mean the fixed minimum
    localparam logic [7:0] STOP_FLOOR_STEP   = 8'h06;
    localparam logic [9:0] STOP_FLOOR_CODE   = 10'h014;
    // level of the monitor enable that makes the measurement valid
    localparam logic       MON_ON_ACTIVE     = 1'b1;
    // transmit buffer depth and width
    localparam int BUF_DEPTH = 8;
    localparam int BUF_WIDTH = 8;
    // frame kinds sent on the line
    typedef enum logic [2:0] {
        KIND_SOP, KIND_SOP1, KIND_SOP2, KIND_DBG1, KIND_DBG2,
        KIND_HARD_RESET, KIND_CABLE_RESET, KIND_BIST_MODE2
    } outgoing_frame_kind_t;
endpackage

// *** hw/byte_fifo.sv ***
// small synchronous fifo holding outgoing payload bytes
// assumes one clock; flush empties it in one cycle
`timescale 1ns/1ns
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             clock,
    input  wire logic             rst,
    input  wire logic             flush,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];        // storage
    logic [AW-1:0]    wr_ptr_q;             // next slot to fill
    logic [AW-1:0]    rd_ptr_q;             // next slot to drain
    logic [AW:0]      count_q;              // bytes held
    logic             push;
    logic             pop;

    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    // full at DEPTH bytes; a flush cycle takes nothing in
    assign in_ready  = (count_q != (AW+1)'(DEPTH)) && !flush;
    assign out_valid = (count_q != '0);
    assign out_data  = mem_q[rd_ptr_q];

    // ==========================================================
    // storage, written only where the write pointer points
    always_ff @(posedge clock) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_data;
        end
    end

    // ==========================================================
    // pointers and fill level; flush wins over any transfer
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q  <= '0;
        end else if (flush) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q  <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= AW'(wr_ptr_q + 1'b1);
            end
            if (pop) begin
                rd_ptr_q <= AW'(rd_ptr_q + 1'b1);
            end
            count_q <= (AW+1)'(count_q + push - pop);
        end
    end
endmodule

// *** verification/line_model.sv ***
// line side stand-in: drains outgoing bytes and ends each attempt
// assumes the register block's single clock and active high reset
`timescale 1ns/1ns
module line_model (
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic       slow,          // stall every other cycle
    input  wire logic       abort,         // end attempt early, discarded
    input  wire logic       tx_start,
    input  wire logic [7:0] tx_length,
    input  wire logic       tx_data_valid,
    output logic            tx_data_ready,
    input  wire logic [7:0] tx_data,
    output logic            tx_done
);
    // ==========================================
    // drain and finish
    logic [7:0] got[$];  // bytes seen on the line, in order
    int         cnt;     // bytes taken in this attempt
    int         want;    // bytes announced at the start
    logic       active;  // attempt in progress
    logic       pop;     // byte handed over at this edge
    assign pop = tx_data_valid && tx_data_ready;
    // ready stays low outside attempts, so nothing drains while loading
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            tx_data_ready <= 1'b0;
            tx_done       <= 1'b0;
            active        <= 1'b0;
            cnt           <= 0;
            want          <= 0;
        end else begin
            tx_done <= 1'b0;
            if (tx_start) begin
                // a request starts a new attempt
                active <= 1'b1;
                want   <= int'(tx_length);
                cnt    <= 0;
            end else if (active) begin
                if (pop)
                    got.push_back(tx_data);
                cnt <= cnt + int'(pop);
                if (abort || cnt + int'(pop) >= want) begin
                    // success or discard both end with one done pulse
                    tx_done       <= 1'b1;
                    active        <= 1'b0;
                    tx_data_ready <= 1'b0;
                end else begin
                    tx_data_ready <= slow ? ~tx_data_ready : 1'b1;
                end
            end
        end
    end
endmodule

// *** verification/testbench.sv ***
// self-checking bench for the transmit and bus voltage register block
// assumes the design under hw/ and the line model beside this file
`timescale 1ns/1ns
module testbench
    import pd_regs_pkg::*;
;
    // ==========================================
    // signals
    logic       clock, rst, xact_start, reg_wr, reg_rd, adc_valid;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, tx_length, tx_data;
    logic       payload_ready, clear_outgoing_pointer_cmd, volt_monitor_on;
    logic [9:0] adc_code, discharge_stop_level, stop_level_eff;
    logic       tx_start, tx_busy, tx_done, tx_data_valid, tx_data_ready;
    logic [2:0] outgoing_frame_kind, s_kind;  // s_ are taken at the start
    logic [1:0] tx_retries, s_ret;
    logic [7:0] s_len;
    logic       slow, abort;                  // line model controls
    int         miscompares, check_count, starts;

    pd_transmit_and_vbus_regs u_dut (.clock, .rst, .xact_start, .reg_wr,
        .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .payload_ready,
        .clear_outgoing_pointer_cmd, .volt_monitor_on, .adc_valid,
        .adc_code, .tx_start, .outgoing_frame_kind, .tx_retries, .tx_length,
        .tx_busy, .tx_done, .tx_data_valid, .tx_data_ready, .tx_data,
        .discharge_stop_level, .stop_level_eff);
    line_model u_line (.clock, .rst, .slow, .abort, .tx_start, .tx_length,
        .tx_data_valid, .tx_data_ready, .tx_data, .tx_done);

    // ==========================================
    // clock and start pulse capture
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    always @(posedge clock) begin
        if (tx_start === 1'b1) begin
            starts <= starts + 1;
            s_kind <= outgoing_frame_kind;
            s_ret  <= tx_retries;
            s_len  <= tx_length;
        end
    end

    // ==========================================
    // shared tasks; every drive lands 1 ns after a rising edge
    task automatic check(input logic [9:0] seen, input logic [9:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick;
        @(posedge clock);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        tick;
        reg_wr = 1'b0;
        tick;
    endtask
    // read data is registered, so it is looked at after the taking edge
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        reg_addr = a;
        reg_rd   = 1'b1;
        tick;
        reg_rd = 1'b0;
        check(10'(reg_rdata), 10'(exp));
        tick;
    endtask
    // one write transaction: count byte first, then n payload bytes
    task automatic load(input int cnt, input int n, input logic [7:0] b);
        xact_start = 1'b1;
        tick;
        xact_start = 1'b0;
        reg_addr   = TX_PAYLOAD_OFS;
        reg_wdata  = 8'(cnt);  // count leads each burst
        reg_wr     = 1'b1;
        for (int i = 0; i < n; i++) begin
            tick;
            reg_wdata = b + 8'(i);
        end
        tick;
        reg_wr = 1'b0;
        tick;
    endtask
    task automatic finish_tx;
        int n;
        n = 0;
        while (tx_busy !== 1'b0 && n < 400) begin
            tick;
            n++;
        end
        check(10'(tx_busy), 10'h000);  // busy ends with the attempt
    endtask
    task automatic check_got(input int n, input logic [7:0] b);
        check(10'(u_line.got.size()), 10'(n));
        for (int i = 0; i < n; i++)
            check(10'(u_line.got[i]), 10'(b + 8'(i)));
        u_line.got.delete();
    endtask

    // ==========================================
    // scenarios
    task automatic t_reset;
        check(discharge_stop_level, 10'h020);
        check(stop_level_eff, 10'h020);
        check(10'(payload_ready), 10'h001);
        rdc(TX_REQUEST_OFS, 8'h00);
        rdc(TX_PAYLOAD_OFS, 8'h00);
        rdc(MEAS_LOW_OFS, 8'h00);
        rdc(MEAS_HIGH_OFS, 8'h00);
        rdc(STOP_LOW_OFS, 8'h20);
        rdc(STOP_HIGH_OFS, 8'h00);
        rdc(8'h33, 8'h00);  // unmapped place reads zero
    endtask
    // every frame kind and retry count, lengths one to eight
    task automatic t_kinds;
        int s0;
        for (int k = 0; k < 8; k++) begin
            s0 = starts;
            load(k + 1, k + 1, 8'(16 * k));
            rdc(TX_PAYLOAD_OFS, 8'h00);
            wr(TX_REQUEST_OFS, {2'h0, 2'(k), 1'b0, 3'(k)});
            check(10'(starts - s0), 10'h001);
            check(10'(s_kind), 10'(k));
            check(10'(s_ret), 10'(k % 4));
            check(10'(s_len), 10'(k + 1));
            rdc(TX_REQUEST_OFS, {2'h0, 2'(k), 1'b0, 3'(k)});
            finish_tx;
            check_got(k + 1, 8'(16 * k));
        end
    endtask
    task automatic t_clear;
        load(3, 3, 8'h20);
        clear_outgoing_pointer_cmd = 1'b1;
        tick;
        clear_outgoing_pointer_cmd = 1'b0;
        load(2, 2, 8'h30);
        wr(TX_REQUEST_OFS, 8'h00);
        check(10'(s_len), 10'h002);
        finish_tx;
        check_got(2, 8'h30);  // older bytes gone
    endtask
    // discard in mid-message under a stalling line, then a clean message
    task automatic t_abort;
        int n;
        slow = 1'b1;
        load(4, 4, 8'h60);
        wr(TX_REQUEST_OFS, 8'h01);
        n = 0;
        while (u_line.got.size() < 1 && n < 100) begin
            tick;
            n++;
        end
        abort = 1'b1;
        finish_tx;
        abort = 1'b0;
        slow  = 1'b0;
        tick;
        check(10'(tx_data_valid), 10'h000);  // buffer emptied
        u_line.got.delete();
        load(1, 1, 8'h70);
        wr(TX_REQUEST_OFS, 8'h00);
        check(10'(s_len), 10'h001);  // pointer cleared
        finish_tx;
        check_got(1, 8'h70);
    endtask
    // nine bytes into eight places, and a byte beyond the count
    task automatic t_over;
        load(9, 9, 8'h80);
        check(10'(payload_ready), 10'h000);  // buffer full
        wr(TX_REQUEST_OFS, 8'h00);
        for (int n = 0; n < 100 && u_line.got.size() < 8; n++)
            tick;
        abort = 1'b1;
        finish_tx;
        abort = 1'b0;
        check_got(8, 8'h80);
        load(2, 3, 8'h40);
        wr(TX_REQUEST_OFS, 8'h00);
        finish_tx;
        check_got(2, 8'h40);  // extra byte dropped
    endtask
    task automatic adc(input logic [9:0] c);
        adc_code  = c;
        adc_valid = 1'b1;
        tick;
        adc_valid = 1'b0;
        tick;
    endtask
    task automatic t_meas;
        volt_monitor_on = 1'b1;
        adc(10'h2A5);
        rdc(MEAS_LOW_OFS, 8'hA5);
        rdc(MEAS_HIGH_OFS, 8'h02);  // scale field zero
        volt_monitor_on = 1'b0;
        adc(10'h155);
        rdc(MEAS_LOW_OFS, 8'hA5);  // no update while off
        wr(MEAS_LOW_OFS, 8'hFF);
        rdc(MEAS_LOW_OFS, 8'hA5);  // read only
        volt_monitor_on = 1'b1;
        adc(10'h3FF);
        rdc(MEAS_HIGH_OFS, 8'h03);
    endtask
    task automatic t_stop;
        logic [9:0] c[7] = '{10'h000, 10'h018, 10'h01B, 10'h01C,
                             10'h021, 10'h3FF, 10'h123};
        logic [9:0] e;
        foreach (c[i]) begin
            e = (c[i] < 10'h01C) ? 10'h014 : (c[i] & 10'h3FC);
            wr(STOP_LOW_OFS, c[i][7:0]);
            wr(STOP_HIGH_OFS, {6'h00, c[i][9:8]});
            check(discharge_stop_level, c[i]);
            check(stop_level_eff, e);
            rdc(STOP_LOW_OFS, c[i][7:0]);
            rdc(STOP_HIGH_OFS, {6'h00, c[i][9:8]});
        end
    endtask

    // ==========================================
    // verdict and main sequence
    task automatic conclude;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clock);
        miscompares++;
        conclude;
    end
    initial begin
        rst = 1'b1;
        {xact_start, reg_wr, reg_rd, adc_valid, slow, abort} = 6'h00;
        {clear_outgoing_pointer_cmd, volt_monitor_on} = 2'h0;
        {reg_addr, reg_wdata, adc_code} = 26'h0;
        miscompares = 0;
        check_count = 0;
        starts      = 0;
        repeat (4) @(posedge clock);
        #1;
        rst = 1'b0;
        tick;
        t_reset;
        t_kinds;
        t_clear;
        t_abort;
        t_over;
        t_meas;
        t_stop;
        conclude;
    end
endmodule
